// *** hdl/gpgc_top.sv ***
// Port-block global configuration register and the port register bank it guards
`timescale 1ns/1ps
module gpgc_top
    import gpgc_pkg::*;
#(
    parameter int MS_CYCLES = GPGC_MS_CYCLES
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    // Internal register port from the serial-bus slave
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    // Events and state from neighbouring logic
    input  wire logic       bus_timeout_evt,
    input  wire logic       key_sleep,
    // Port pins
    input  wire logic [7:0] port_pin_in,
    // Port-block outputs
    output logic            port_irq_out,
    output logic            rotary_mode,
    output logic            rotary_phase_a_pin,
    output logic            rotary_phase_b_pin,
    output logic [7:0]      general_input,
    output logic [7:0]      general_output,
    output logic            pwm_enable,
    output logic            ccs_enable,
    output logic            gpi_enable,
    output logic            full_power_down,
    output logic [2:0]      fade_code,
    output logic            fade_step_tick,
    output logic [3:0]      fade_step_idx
);
    logic [7:0] cfg;                          // Stored global configuration
    logic [7:0] next_cfg;
    logic [7:0] bank [GPGC_BANK_DEPTH];       // Port registers 0x41..0x5F
    logic [7:0] next_bank [GPGC_BANK_DEPTH];
    logic       tmo_flag;                     // Sticky bus-timeout flag
    logic       next_tmo_flag;
    logic [7:0] next_reg_rdata;
    logic [7:0] pin_meta;                     // First synchroniser stage
    logic [7:0] pin_sync;                     // Second synchroniser stage
    logic [7:0] next_general_input;
    logic       blk_en;                       // Global enable bit
    logic       soft_rst;                     // Reset write this cycle
    logic       in_bank;                      // Address falls in the bank
    logic [4:0] bank_idx;                     // Bank index of address
    logic [4:0] gpo_idx;                      // Bank index of output levels
    logic       cfg_wr;                       // Write to the configuration register
    logic       bank_wr;                      // Write aimed at the port bank
    logic       flag_rd;                      // Read of the timeout flag register
    logic       fade_run;                     // Fade ramp allowed to run

    // Bank index from a register address
    function automatic logic [4:0] idx_of(input logic [7:0] addr);
        logic [7:0] diff;
        diff = addr - GPGC_BANK_FIRST;
        idx_of = diff[4:0];
    endfunction

    // Address decode and enables
    always_comb begin
        // Global enable from the stored register
        blk_en   = cfg[GPGC_EN_BIT];
        // Bank address range and the slot it points at
        in_bank  = (reg_addr >= GPGC_BANK_FIRST) && (reg_addr <= GPGC_BANK_LAST);
        bank_idx = idx_of(reg_addr);
        // Bank slot that holds the output levels
        gpo_idx  = idx_of(GPGC_GPO_ADDR);
        // Write to the global configuration register
        cfg_wr   = reg_wr && (reg_addr == GPGC_CFG_ADDR);
        // Write aimed at the bank; the flag register is read-only
        bank_wr  = reg_wr && in_bank && (reg_addr != GPGC_TMO_FLAG_ADDR);
        // Read of the timeout flag register
        flag_rd  = reg_rd && (reg_addr == GPGC_TMO_FLAG_ADDR);
        soft_rst = cfg_wr && reg_wdata[GPGC_SRST_BIT];
    end

    // Next values of configuration, bank and timeout flag
    always_comb begin
        next_cfg      = cfg;
        next_bank     = bank;
        next_tmo_flag = tmo_flag;
        // Self-clearing reset wins over any other write in its cycle
        if (soft_rst) begin
            // Whole port register range back to reset values
            next_cfg = GPGC_CFG_RST;
            for (int i = 0; i < GPGC_BANK_DEPTH; i++) begin
                next_bank[i] = GPGC_BANK_RST;
            end
            next_tmo_flag = 1'b0;
        end else if (cfg_wr) begin
            // Reserved and self-clearing bits are never stored
            next_cfg = reg_wdata & GPGC_CFG_KEEP;
        end else if (bank_wr && blk_en) begin
            // Bank accepts writes only while enabled
            next_bank[bank_idx] = reg_wdata;
        end
        // Read of the flag register clears it
        if (flag_rd) begin
            next_tmo_flag = 1'b0;
        end
        // A timeout in the same cycle still lands
        if (bus_timeout_evt) begin
            next_tmo_flag = 1'b1;
        end
    end

    // Read data, registered one cycle after the strobe
    always_comb begin
        next_reg_rdata = reg_rdata;
        if (reg_rd) begin
            if (reg_addr == GPGC_CFG_ADDR) begin
                // D6 and D3 always read zero
                next_reg_rdata = cfg & GPGC_CFG_KEEP;
            end else if (reg_addr == GPGC_TMO_FLAG_ADDR) begin
                // Flag in bit 0; the same read clears it
                next_reg_rdata = {7'h00, tmo_flag};
            end else if (in_bank) begin
                // Bank contents stay readable while frozen
                next_reg_rdata = bank[bank_idx];
            end else begin
                // Unmapped address
                next_reg_rdata = 8'h00;
            end
        end
    end

    // Input sampling: held frozen while the inputs are shut down
    always_comb begin
        // Disabled inputs keep their last sample
        next_general_input = general_input;
        if (blk_en) begin
            // Enabled: follow the synchronised pins
            next_general_input = pin_sync;
        end
    end

    // Configuration, bank and timeout flag registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg           <= GPGC_CFG_RST;
            for (int i = 0; i < GPGC_BANK_DEPTH; i++) begin
                bank[i] <= GPGC_BANK_RST;
            end
            tmo_flag      <= 1'b0;
        end else begin
            cfg           <= next_cfg;
            bank          <= next_bank;
            tmo_flag      <= next_tmo_flag;
        end
    end

    // Read data register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata     <= 8'h00;
        end else begin
            reg_rdata     <= next_reg_rdata;
        end
    end

    // Two-flop pin synchroniser and the sampled input register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_meta      <= 8'h00;
            pin_sync      <= 8'h00;
            general_input <= 8'h00;
        end else begin
            // Only the second stage reads the first
            pin_meta      <= port_pin_in;
            pin_sync      <= pin_meta;
            general_input <= next_general_input;
        end
    end

    // Output decode from stored state
    always_comb begin
        // Interrupt only while the timeout source is enabled
        port_irq_out       = tmo_flag && cfg[GPGC_TMO_IE_BIT];
        rotary_mode        = cfg[GPGC_ROT_BIT];
        // Rotary pair reported only in rotary mode; frozen while disabled
        rotary_phase_a_pin = rotary_mode && general_input[6];
        rotary_phase_b_pin = rotary_mode && general_input[7];
        // Output levels come straight from the bank, never forced
        general_output     = bank[gpo_idx];
        // Circuit enables follow the global enable bit alone
        pwm_enable         = blk_en;
        ccs_enable         = blk_en;
        gpi_enable         = blk_en;
        // Whole device sleeps only with the port block off and keys asleep
        full_power_down    = !blk_en && key_sleep;
        // Fade code passes straight to the ramp timer
        fade_code          = cfg[2:0];
        // Ramp runs only while enabled and for a defined nonzero code
        fade_run           = blk_en && (fade_code != GPGC_FADE_OFF)
                             && (fade_code <= GPGC_FADE_MAX);
    end

    // Fade step timing; codes above the last defined one do not fade
    gpgc_fade_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_fade (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .run        (fade_run),
        .fade_code  (fade_code),
        .step_tick  (fade_step_tick),
        .step_idx   (fade_step_idx)
    );
endmodule

// *** hdl/gpgc_pkg.sv ***
// Shared constants for the port-block global configuration logic
package gpgc_pkg;
    // Register addresses
    localparam logic [7:0] GPGC_CFG_ADDR      = 8'h40;
    localparam logic [7:0] GPGC_BANK_FIRST    = 8'h41;
    localparam logic [7:0] GPGC_BANK_LAST     = 8'h5F;
    localparam logic [7:0] GPGC_TMO_FLAG_ADDR = 8'h48;
    localparam logic [7:0] GPGC_GPO_ADDR      = 8'h43;
    localparam int         GPGC_BANK_DEPTH    = 31;
    // Field positions of the global configuration register
    localparam int         GPGC_ROT_BIT       = 7;
    localparam int         GPGC_RSV_BIT       = 6;
    localparam int         GPGC_TMO_IE_BIT    = 5;
    localparam int         GPGC_EN_BIT        = 4;
    localparam int         GPGC_SRST_BIT      = 3;
    // Bits kept in storage; reserved and self-clearing bits excluded
    localparam logic [7:0] GPGC_CFG_KEEP      = 8'hB7;
    // Values after reset
    localparam logic [7:0] GPGC_CFG_RST       = 8'h00;
    localparam logic [7:0] GPGC_BANK_RST      = 8'h00;
    // Fade codes
    localparam logic [2:0] GPGC_FADE_OFF      = 3'h0;
    localparam logic [2:0] GPGC_FADE_MAX      = 3'h5;
    localparam int         GPGC_FADE_STEPS    = 16;
    localparam int         GPGC_FADE_BASE_MS  = 256;
    // One millisecond at the 100 MHz core clock
    localparam int         GPGC_CLK_MHZ       = 100;
    localparam int         GPGC_MS_CYCLES     = GPGC_CLK_MHZ * 1000;
    // Milliseconds per fade step at the shortest code
    localparam int         GPGC_STEP_BASE_MS  = GPGC_FADE_BASE_MS / GPGC_FADE_STEPS;
    // Fade state
    typedef enum logic [0:0] {
        GPGC_FADE_IDLE = 1'b0,
        GPGC_FADE_RUN  = 1'b1
    } gpgc_fade_e;
endpackage

// *** hdl/gpgc_fade_timer.sv ***
// Fade step timer: 16 equal steps over 256 ms times two to the code minus one
`timescale 1ns/1ps
module gpgc_fade_timer
    import gpgc_pkg::*;
#(
    parameter int MS_CYCLES = GPGC_MS_CYCLES
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    // Control
    input  wire logic       run,
    input  wire logic [2:0] fade_code,
    // Step output
    output logic            step_tick,
    output logic [3:0]      step_idx
);
    gpgc_fade_e  state;          // Idle or running
    gpgc_fade_e  next_state;
    logic [16:0] ms_cnt;         // Millisecond prescaler
    logic [16:0] next_ms_cnt;
    logic [8:0]  step_ms;        // Milliseconds elapsed in current step
    logic [8:0]  next_step_ms;
    logic [3:0]  next_step_idx;
    logic        next_step_tick;
    logic [8:0]  step_len;       // Step length in ms for this code

    // Step length doubles with each fade code
    function automatic logic [8:0] step_len_ms(input logic [2:0] code);
        logic [8:0] base;
        base = 9'(GPGC_STEP_BASE_MS);
        step_len_ms = base << (code - 3'h1);
    endfunction

    // Next-state logic for prescaler, step counter and index
    always_comb begin
        step_len        = step_len_ms(fade_code);
        next_state      = state;
        next_ms_cnt     = ms_cnt;
        next_step_ms    = step_ms;
        next_step_idx   = step_idx;
        next_step_tick  = 1'b0;
        case (state)
            GPGC_FADE_IDLE: begin
                // Start from a clean count
                next_ms_cnt   = 17'h00000;
                next_step_ms  = 9'h000;
                next_step_idx = 4'h0;
                if (run) begin
                    next_state = GPGC_FADE_RUN;
                end
            end
            GPGC_FADE_RUN: begin
                if (!run) begin
                    next_state = GPGC_FADE_IDLE;
                end else if (ms_cnt == 17'(MS_CYCLES - 1)) begin
                    next_ms_cnt = 17'h00000;
                    // At or past the step end, so a shorter code set mid-step cannot overrun
                    if (step_ms >= step_len - 9'h001) begin
                        // One of 16 steps done
                        next_step_ms    = 9'h000;
                        next_step_idx   = step_idx + 4'h1;
                        next_step_tick  = 1'b1;
                    end else begin
                        next_step_ms = step_ms + 9'h001;
                    end
                end else begin
                    next_ms_cnt = ms_cnt + 17'h00001;
                end
            end
            default: begin
                next_state = GPGC_FADE_IDLE;
            end
        endcase
    end

    // Registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state      <= GPGC_FADE_IDLE;
            ms_cnt     <= 17'h00000;
            step_ms    <= 9'h000;
            step_idx   <= 4'h0;
            step_tick  <= 1'b0;
        end else begin
            state      <= next_state;
            ms_cnt     <= next_ms_cnt;
            step_ms    <= next_step_ms;
            step_idx   <= next_step_idx;
            step_tick  <= next_step_tick;
        end
    end
endmodule

// *** verification/gpgc_asserts.sv ***
// Checker for the port-block global configuration register
`timescale 1ns/1ps
module gpgc_asserts
    import gpgc_pkg::*;
(
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       arst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Events and outputs
    input wire logic       bus_timeout_evt,
    input wire logic       key_sleep,
    input wire logic       port_irq_out,
    input wire logic       rotary_mode,
    input wire logic [7:0] general_output,
    input wire logic       pwm_enable,
    input wire logic       ccs_enable,
    input wire logic       gpi_enable,
    input wire logic       full_power_down,
    input wire logic [2:0] fade_code,
    input wire logic       fade_step_tick
);
    logic [7:0] cfg;      // Expected configuration contents
    logic [7:0] next_cfg; // Its next value
    // Shadow of the configuration register; a D3 write clears all
    always_comb begin
        next_cfg = cfg;
        if (reg_wr && reg_addr == GPGC_CFG_ADDR) begin
            next_cfg = reg_wdata[3] ? 8'h00 : (reg_wdata & GPGC_CFG_KEEP);
        end
    end
    // Shadow storage
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg <= 8'h00;
        end else begin
            cfg <= next_cfg;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Timeout seen while enabled, and the clearing read
    sequence s_evt; bus_timeout_evt && cfg[5] && !reg_wr; endsequence
    sequence s_clr; reg_rd && reg_addr == GPGC_TMO_FLAG_ADDR && !bus_timeout_evt; endsequence
    AST_ROT: assert property (reg_wr && reg_addr == GPGC_CFG_ADDR && !reg_wdata[3]
        |=> rotary_mode == $past(reg_wdata[7])) else $error("rotary mode wrong");
    AST_IRQ_SET: assert property (s_evt |=> port_irq_out)
        else $error("timeout irq missing");
    AST_IRQ_MASK: assert property (!cfg[5] |-> !port_irq_out)
        else $error("masked irq raised");
    AST_IRQ_CLR: assert property (s_clr |=> !port_irq_out)
        else $error("irq not cleared");
    AST_EN: assert property (pwm_enable == cfg[4] && ccs_enable == cfg[4]
        && gpi_enable == cfg[4]) else $error("enables wrong");
    AST_PD: assert property (full_power_down == (!cfg[4] && key_sleep))
        else $error("power down wrong");
    AST_FADE: assert property (fade_code == cfg[2:0])
        else $error("fade code wrong");
    AST_STEP: assert property (fade_step_tick |-> $past(cfg[4]))
        else $error("fade step while disabled");
    AST_FREEZE: assert property (!cfg[4] && reg_wr && reg_addr == GPGC_GPO_ADDR
        |=> $stable(general_output)) else $error("frozen output changed");
    AST_RSV: assert property (reg_rd && !reg_wr && reg_addr == GPGC_CFG_ADDR
        |=> reg_rdata == $past(cfg)) else $error("config readback wrong");
    AST_SRST: assert property (reg_wr && reg_addr == GPGC_CFG_ADDR && reg_wdata[3]
        |=> !rotary_mode && !pwm_enable && !port_irq_out && fade_code == 3'h0
        && general_output == 8'h00) else $error("port reset incomplete");
endmodule
bind gpgc_top gpgc_asserts u_chk (.core_clk, .arst_n, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .bus_timeout_evt, .key_sleep, .port_irq_out, .rotary_mode,
    .general_output, .pwm_enable, .ccs_enable, .gpi_enable, .full_power_down,
    .fade_code, .fade_step_tick);

// *** verification/gpgc_host.sv ***
// Host model driving the internal register port
`timescale 1ns/1ps
module gpgc_host (
    // Clock
    input  wire logic       core_clk,
    // Register port
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic [7:0]      reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    // Idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // One-cycle write; data shown inverted once no longer qualified
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // One-cycle read; a read of the flag register clears it
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the global configuration register block
`timescale 1ns/1ps
module tb;
    import gpgc_pkg::*;
    logic       core_clk, arst_n, reg_wr, reg_rd, bus_timeout_evt, key_sleep;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, port_pin_in, general_input, general_output;
    logic       port_irq_out, rotary_mode, rotary_phase_a_pin, rotary_phase_b_pin;
    logic       pwm_enable, ccs_enable, gpi_enable, full_power_down, fade_step_tick;
    logic [2:0] fade_code;
    logic [3:0] fade_step_idx;
    logic [7:0] v, r, p, e;
    int         bad_count, n_checks, n;
    gpgc_top #(.MS_CYCLES(4)) dut (.core_clk, .arst_n, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .bus_timeout_evt, .key_sleep, .port_pin_in, .port_irq_out,
        .rotary_mode, .rotary_phase_a_pin, .rotary_phase_b_pin, .general_input,
        .general_output, .pwm_enable, .ccs_enable, .gpi_enable, .full_power_down,
        .fade_code, .fade_step_tick, .fade_step_idx);
    gpgc_host u_host (.core_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
    // Byte compare
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Cycle-count compare
    task automatic chk_cnt(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Verdict and end of run
    task automatic close_out();
        if (bad_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Expected readback of a configuration write
    function automatic logic [7:0] exp_cfg(input logic [7:0] w);
        return w[3] ? 8'h00 : (w & GPGC_CFG_KEEP);
    endfunction
    // One timeout event, output looked at after the capturing edge
    task automatic tmo();
        @(posedge core_clk) bus_timeout_evt <= 1'b1;
        @(posedge core_clk) bus_timeout_evt <= 1'b0;
        #1;
    endtask
    // Cycles until the next fade step, bounded
    task automatic step_gap(output int k);
        k = 0;
        do begin
            @(posedge core_clk);
            #1 k++;
        end while (fade_step_tick !== 1'b1 && k < 5000);
    endtask
    // Clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Watchdog
    initial begin
        #300000;
        bad_count++;
        close_out();
    end
    // Main sequence
    initial begin
        arst_n = 1'b0;
        bus_timeout_evt = 1'b0;
        key_sleep = 1'b0;
        port_pin_in = 8'h00;
        void'($urandom(19825));
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        u_host.rd(GPGC_CFG_ADDR, r);
        chk(r, 8'h00);
        // Sixteen random settings, each read back and checked at the outputs
        repeat (16) begin
            v = 8'($urandom);
            @(posedge core_clk) key_sleep <= 1'($urandom);
            u_host.wr(GPGC_CFG_ADDR, v);
            u_host.rd(GPGC_CFG_ADDR, r);
            e = exp_cfg(v);
            chk(r, e);
            chk({5'h00, pwm_enable, ccs_enable, gpi_enable}, {5'h00, {3{e[4]}}});
            chk({7'h00, full_power_down}, {7'h00, !e[4] && key_sleep});
            chk({7'h00, rotary_mode}, {7'h00, e[7]});
            chk({5'h00, fade_code}, {5'h00, e[2:0]});
        end
        // Timeout masked, flag read, then enabled
        u_host.wr(GPGC_CFG_ADDR, 8'h10);
        tmo();
        chk({7'h00, port_irq_out}, 8'h00);
        u_host.rd(GPGC_TMO_FLAG_ADDR, r);
        chk(r, 8'h01);
        u_host.wr(GPGC_CFG_ADDR, 8'h30);
        tmo();
        chk({7'h00, port_irq_out}, 8'h01);
        u_host.rd(GPGC_TMO_FLAG_ADDR, r);
        chk({7'h00, port_irq_out}, 8'h00);
        chk(r, 8'h01);
        // Rotary pair follows pins 6 and 7
        u_host.wr(GPGC_CFG_ADDR, 8'h90);
        p = 8'($urandom);
        @(posedge core_clk) port_pin_in <= p;
        repeat (5) @(posedge core_clk);
        #1 chk({6'h00, rotary_phase_b_pin, rotary_phase_a_pin}, {6'h00, p[7:6]});
        chk(general_input, p);
        // Output level kept, bank frozen, inputs frozen while disabled
        u_host.wr(GPGC_GPO_ADDR, 8'hA5);
        u_host.wr(GPGC_CFG_ADDR, 8'h00);
        u_host.wr(GPGC_GPO_ADDR, 8'h3C);
        @(posedge core_clk) port_pin_in <= ~p;
        u_host.rd(GPGC_GPO_ADDR, r);
        repeat (4) @(posedge core_clk);
        #1 chk(r, 8'hA5);
        chk(general_output, 8'hA5);
        chk(general_input, p);
        chk({6'h00, rotary_phase_b_pin, rotary_phase_a_pin}, 8'h00);
        // Bank reset through D3, then an unmapped read
        u_host.wr(GPGC_CFG_ADDR, 8'h18);
        u_host.rd(GPGC_GPO_ADDR, r);
        chk(r, 8'h00);
        u_host.rd(8'h60, r);
        chk(r, 8'h00);
        // Fade step spacing for every defined code
        for (int c = 1; c <= 5; c++) begin
            u_host.wr(GPGC_CFG_ADDR, {5'h02, c[2:0]});
            step_gap(n);
            step_gap(n);
            chk_cnt(n, GPGC_FADE_BASE_MS / GPGC_FADE_STEPS * 4 << (c - 1));
            if (c == 1) begin
                chk({4'h0, fade_step_idx}, 8'h02);
            end
        end
        // Undefined code: no step at all within the bound
        u_host.wr(GPGC_CFG_ADDR, 8'h16);
        step_gap(n);
        chk_cnt(n, 5000);
        close_out();
    end
endmodule
